// ==== verilog/bmc_regs.sv ====
// basic mode control register bank with apb slave and mii steering
// assumes apb master on core_clk; strap and status inputs synchronous to core_clk
//
// Functional notes
// - writing one to bit 15 resets; reads one until done, then restraps.
// - bit 14 loops mii transmit data back to mii receive.
// - with negotiation off, bit 13 selects 100 Mb/s (1) or 10 Mb/s (0).
// - bit 12 on ignores bits 13 and 8; off lets them rule.
// - negotiation enable loads from its strap pin at reset.
// - bit 11 powers down; register access keeps working.
// - bit 10 isolates the port from the mii; management stays alive.
// - clear-on-read fields return their value, then clear after the read.
// - latched-low fields drop on event and stay low until read.
// - latched-high fields rise on event and stay high until read.
// - self-clearing fields follow their event and clear when it ends.
// - permanent read-only fields keep their value; writes do nothing.
// - with negotiation off, bit 8 selects full (1) or half (0) duplex.
// - bit 9 restarts negotiation, clears once started, ignored when off.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
module bmc_regs #(
	parameter int unsigned DW = 4
) (
	input  wire logic                       core_clk,
	input  wire logic                       nrst,
	// apb slave
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [bmc_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]                pwdata,
	input  wire logic [3:0]                 pstrb,
	output logic [31:0]                     prdata,
	output logic                            pready,
	output logic                            pslverr,
	// straps
	input  wire logic                       strap_an_en,
	input  wire logic                       strap_speed_100,
	input  wire logic                       strap_full_duplex,
	// negotiation engine
	input  wire logic                       an_speed_100,
	input  wire logic                       an_full_duplex,
	input  wire logic                       an_started,
	output logic                            an_enable,
	output logic                            an_restart,
	// status events
	input  wire logic                       link_up,
	input  wire logic                       selftest_err,
	input  wire logic                       ed_err_met,
	input  wire logic                       ed_pwr_state,
	// mode outputs
	output logic                            soft_reset,
	output logic                            speed_100,
	output logic                            full_duplex,
	output logic                            power_down,
	output logic                            coll_test,
	output logic [5:0]                      test_pattern_ctrl,
	output logic [4:0]                      energy_detect_ctrl,
	// mii data
	input  wire logic                       mii_tx_en,
	input  wire logic [DW-1:0]              mii_txd,
	input  wire logic                       line_rx_dv,
	input  wire logic [DW-1:0]              line_rxd,
	output logic                            mii_rx_dv,
	output logic [DW-1:0]                   mii_rxd,
	output logic                            line_tx_en,
	output logic [DW-1:0]                   line_txd
);
	import bmc_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		bmc_state_t          st;
		logic [SWRST_CW-1:0] cnt;
		logic [15:0]         bmc;
		logic [15:0]         tpc;
		logic [15:0]         edc;
		logic [7:0]          errcnt;
		logic                ed_pwr;
		logic [7:0]          snap_cnt;
		logic                snap_met;
		logic                snap_link;
		logic [31:0]         rdata;
		logic                speed_eff;
		logic                dup_eff;
	} bmc_regs_st_t;

	localparam bmc_regs_st_t ST_RESET = '{
		st: ST_INIT, cnt: '0, bmc: BMC_RST_VAL, tpc: TPC_RST_VAL, edc: EDC_RST_VAL,
		errcnt: '0, ed_pwr: 1'b0, snap_cnt: '0, snap_met: 1'b0, snap_link: 1'b0,
		rdata: '0, speed_eff: 1'b0, dup_eff: 1'b0};

	localparam logic [SWRST_CW-1:0] SWRST_LOAD = SWRST_CW'(SWRST_CYCLES - 1);

	bmc_regs_st_t s_r;
	bmc_regs_st_t s_nxt;

	logic       met_flag;
	logic       link_flag;
	logic [5:0] idx;
	logic       misaligned;
	logic       access;
	logic       wr_done;
	logic       rd_done;

	bmc_mode_if mode_if ();

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// register index that answers without error
	function automatic logic is_mapped(input logic [5:0] i);
		is_mapped = (i == IDX_BMC) || (i == IDX_TPC) || (i == IDX_RSV_1C) ||
			(i == IDX_EDC) || (i == IDX_RSV_1E) || (i == IDX_RSV_1F) || (i == IDX_EVS);
	endfunction

	// byte-lane merge of a write into the writable bits only
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
		input logic [3:0] strb, input logic [15:0] mask);
		logic [15:0] v;
		v = old;
		if (strb[0])
			v[7:0] = wd[7:0];
		if (strb[1])
			v[15:8] = wd[15:8];
		merge16 = (v & mask) | (old & ~mask);
	endfunction

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	assign idx        = paddr[7:2];
	assign misaligned = (paddr[1:0] != 2'b00);
	assign access     = psel && penable;
	assign pready     = 1'b1;
	assign pslverr    = access && (misaligned || !is_mapped(idx));
	assign wr_done    = access && pwrite && !pslverr;
	assign rd_done    = access && !pwrite && !pslverr;

	// ----------------------------------------------------------------
	// latched status flags
	// ----------------------------------------------------------------
	// error-met flag is released only if the read saw it set
	bmc_latch #(
		.LATCH_HIGH (1'b1)
	) u_met_latch (
		.core_clk   (core_clk),
		.nrst       (nrst),
		.event_in   (ed_err_met),
		.release_in (rd_done && (idx == IDX_EDC) && s_r.snap_met),
		.flag       (met_flag)
	);

	// link flag is released only if the read saw it low
	bmc_latch #(
		.LATCH_HIGH (1'b0)
	) u_link_latch (
		.core_clk   (core_clk),
		.nrst       (nrst),
		.event_in   (!link_up),
		.release_in (rd_done && (idx == IDX_EVS) && !s_r.snap_link),
		.flag       (link_flag)
	);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		s_nxt.ed_pwr = ed_pwr_state;
		case (s_r.st)
			// load defaults and sample the straps
			ST_INIT: begin
				s_nxt.bmc              = BMC_RST_VAL;
				s_nxt.bmc[BMC_AN_EN]   = strap_an_en;
				s_nxt.bmc[BMC_SPEED]   = strap_speed_100;
				s_nxt.bmc[BMC_DUPLEX]  = strap_full_duplex;
				s_nxt.tpc              = TPC_RST_VAL;
				s_nxt.edc              = EDC_RST_VAL;
				s_nxt.errcnt           = '0;
				s_nxt.st               = ST_RUN;
			end
			ST_RUN: begin
				// restart clears when the engine starts or negotiation is off
				if (an_started || !s_r.bmc[BMC_AN_EN])
					s_nxt.bmc[BMC_AN_RST] = 1'b0;
				if (wr_done && (idx == IDX_BMC)) begin
					// merge onto the next value so an engine clear of bit 9 survives the write
					s_nxt.bmc = merge16(s_nxt.bmc, pwdata, pstrb, BMC_RW_MASK);
					// a written one wins over the engine's clear
					if (pstrb[1] && pwdata[BMC_AN_RST] && s_nxt.bmc[BMC_AN_EN])
						s_nxt.bmc[BMC_AN_RST] = 1'b1;
					if (pstrb[1] && pwdata[BMC_SWRST]) begin
						s_nxt.bmc[BMC_SWRST] = 1'b1;
						s_nxt.cnt            = SWRST_LOAD;
						s_nxt.st             = ST_SWRST;
					end
				end
				if (wr_done && (idx == IDX_TPC))
					s_nxt.tpc = merge16(s_r.tpc, pwdata, pstrb, TPC_RW_MASK);
				if (wr_done && (idx == IDX_EDC))
					s_nxt.edc = merge16(s_r.edc, pwdata, pstrb, EDC_RW_MASK);
			end
			// hold the reset bit until the count runs out, then restrap
			ST_SWRST: begin
				if (s_r.cnt == '0)
					s_nxt.st = ST_INIT;
				else
					s_nxt.cnt = s_r.cnt - SWRST_CW'(1);
			end
			default: begin
				s_nxt.st = ST_INIT;
			end
		endcase

		// error counter: the read takes away what it returned
		if (rd_done && (idx == IDX_TPC))
			s_nxt.errcnt = s_r.errcnt - s_r.snap_cnt;
		else
			s_nxt.errcnt = (s_r.st == ST_INIT) ? 8'h00 : s_r.errcnt;
		if (selftest_err && (s_nxt.errcnt != TPC_CNT_MAX))
			s_nxt.errcnt = s_nxt.errcnt + 8'h01;

		// read data captured in the setup cycle, returned in the access cycle
		if (psel && !penable) begin
			s_nxt.rdata     = '0;
			s_nxt.snap_cnt  = s_r.errcnt;
			s_nxt.snap_met  = met_flag;
			s_nxt.snap_link = link_flag;
			if (!misaligned) begin
				case (idx)
					IDX_BMC: begin
						s_nxt.rdata[15:0] = s_r.bmc;
					end
					IDX_TPC: begin
						s_nxt.rdata[15:0] = (s_r.tpc & TPC_RW_MASK) |
							{s_r.errcnt, 8'h00};
					end
					IDX_EDC: begin
						s_nxt.rdata[15:0]        = s_r.edc & EDC_RW_MASK;
						s_nxt.rdata[EDC_PWR]     = s_r.ed_pwr;
						s_nxt.rdata[EDC_ERR_MET] = met_flag;
					end
					IDX_EVS: begin
						s_nxt.rdata[15:0]     = EVS_PERM_VAL;
						s_nxt.rdata[EVS_LINK] = link_flag;
					end
					default: begin
						s_nxt.rdata = '0;
					end
				endcase
			end
		end

		// effective speed and duplex
		if (s_r.bmc[BMC_AN_EN]) begin
			s_nxt.speed_eff = an_speed_100;
			s_nxt.dup_eff   = an_full_duplex;
		end else begin
			s_nxt.speed_eff = s_r.bmc[BMC_SPEED];
			s_nxt.dup_eff   = s_r.bmc[BMC_DUPLEX];
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst)
			s_r <= ST_RESET;
		else
			s_r <= s_nxt;
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign prdata             = s_r.rdata;
	assign soft_reset         = (s_r.st != ST_RUN);
	assign an_enable          = s_r.bmc[BMC_AN_EN];
	assign an_restart         = s_r.bmc[BMC_AN_RST];
	assign speed_100          = s_r.speed_eff;
	assign full_duplex        = s_r.dup_eff;
	assign power_down         = s_r.bmc[BMC_PDOWN];
	assign coll_test          = s_r.bmc[BMC_COLTEST];
	assign test_pattern_ctrl  = s_r.tpc[5:0] & TPC_RW_MASK[5:0];
	assign energy_detect_ctrl = s_r.edc[15:11];

	// mode lines to the data path
	assign mode_if.loopback   = s_r.bmc[BMC_LOOP];
	assign mode_if.isolate    = s_r.bmc[BMC_ISO];
	assign mode_if.power_down = s_r.bmc[BMC_PDOWN];

	// ----------------------------------------------------------------
	// data path
	// ----------------------------------------------------------------
	bmc_mii_path #(
		.DW (DW)
	) u_path (
		.core_clk   (core_clk),
		.nrst       (nrst),
		.mode       (mode_if),
		.mii_tx_en  (mii_tx_en),
		.mii_txd    (mii_txd),
		.line_rx_dv (line_rx_dv),
		.line_rxd   (line_rxd),
		.mii_rx_dv  (mii_rx_dv),
		.mii_rxd    (mii_rxd),
		.line_tx_en (line_tx_en),
		.line_txd   (line_txd)
	);
endmodule

// ==== verilog/bmc_pkg.sv ====
// constants, register indices, field positions and types of the basic mode control bank
// assumes a 40 MHz core clock and an APB register port with word-aligned registers
package bmc_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_PS = 25000;                   // 40 MHz core clock
	localparam int unsigned SWRST_TIME_NS = 2000;                    // software reset length
	localparam int unsigned SWRST_CYCLES  =
		(SWRST_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS; // least time, rounded up
	localparam int unsigned SWRST_CW      = 8;

	// ----------------------------------------------------------------
	// apb layout: byte address = 4 * register index
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W     = 8;
	localparam logic [5:0]  IDX_BMC    = 6'h00; // basic_mode_control
	localparam logic [5:0]  IDX_TPC    = 6'h1B; // test_pattern_selftest_control
	localparam logic [5:0]  IDX_RSV_1C = 6'h1C; // reserved_1c
	localparam logic [5:0]  IDX_EDC    = 6'h1D; // energy_detect_control
	localparam logic [5:0]  IDX_RSV_1E = 6'h1E; // reserved_1e_1f, first word
	localparam logic [5:0]  IDX_RSV_1F = 6'h1F; // reserved_1e_1f, second word
	localparam logic [5:0]  IDX_EVS    = 6'h20; // link_event_status

	// ----------------------------------------------------------------
	// basic_mode_control fields
	// ----------------------------------------------------------------
	localparam int unsigned BMC_SWRST   = 15;
	localparam int unsigned BMC_LOOP    = 14;
	localparam int unsigned BMC_SPEED   = 13;
	localparam int unsigned BMC_AN_EN   = 12;
	localparam int unsigned BMC_PDOWN   = 11;
	localparam int unsigned BMC_ISO     = 10;
	localparam int unsigned BMC_AN_RST  = 9;
	localparam int unsigned BMC_DUPLEX  = 8;
	localparam int unsigned BMC_COLTEST = 7;
	localparam logic [15:0] BMC_RW_MASK = 16'h7D80;
	localparam logic [15:0] BMC_RST_VAL = 16'h0000;

	// ----------------------------------------------------------------
	// test_pattern_selftest_control and energy_detect_control fields
	// ----------------------------------------------------------------
	localparam logic [15:0] TPC_RW_MASK = 16'h0037;
	localparam logic [15:0] TPC_RST_VAL = 16'h0000;
	localparam int unsigned TPC_CNT_LSB = 8;
	localparam logic [7:0]  TPC_CNT_MAX = 8'hFF;
	localparam logic [15:0] EDC_RW_MASK = 16'hF8FF;
	localparam logic [15:0] EDC_RST_VAL = 16'h0000;
	localparam int unsigned EDC_PWR     = 10;
	localparam int unsigned EDC_ERR_MET = 9;

	// ----------------------------------------------------------------
	// link_event_status fields
	// ----------------------------------------------------------------
	localparam logic [15:0] EVS_PERM_VAL = 16'h7800;
	localparam int unsigned EVS_LINK     = 0;

	// bank sequencing, one-hot
	typedef enum logic [2:0] {
		ST_INIT  = 3'b001,
		ST_RUN   = 3'b010,
		ST_SWRST = 3'b100
	} bmc_state_t;

endpackage

// ==== verilog/bmc_mode_if.sv ====
// mode lines from the register bank to the data path
// assumes both ends run on the same core clock
`timescale 1ns/1ps
interface bmc_mode_if;
	logic loopback;
	logic isolate;
	logic power_down;

	modport ctl  (output loopback, output isolate, output power_down);
	modport path (input  loopback, input  isolate, input  power_down);
endinterface

// ==== verilog/bmc_latch.sv ====
// one latched status flag, latched-high or latched-low
// assumes event and release are synchronous to core_clk
`timescale 1ns/1ps
module bmc_latch #(
	parameter bit LATCH_HIGH = 1'b1
) (
	input  wire logic core_clk,
	input  wire logic nrst,
	input  wire logic event_in,
	input  wire logic release_in,
	output logic      flag
);
	import bmc_pkg::*;

	typedef struct packed {
		logic flag;
	} bmc_latch_st_t;

	bmc_latch_st_t s_r;
	bmc_latch_st_t s_nxt;

	// event wins over the read that releases the flag
	always_comb begin
		s_nxt = s_r;
		if (LATCH_HIGH) begin
			if (release_in)
				s_nxt.flag = 1'b0;
			if (event_in)
				s_nxt.flag = 1'b1;
		end else begin
			if (release_in)
				s_nxt.flag = 1'b1;
			if (event_in)
				s_nxt.flag = 1'b0;
		end
	end

	// state register
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign flag = s_r.flag;
endmodule

// ==== verilog/bmc_mii_path.sv ====
// mii data steering for loopback, isolate and power down
// assumes transmit and line receive data are synchronous to core_clk
`timescale 1ns/1ps
module bmc_mii_path #(
	parameter int unsigned DW = 4
) (
	input  wire logic          core_clk,
	input  wire logic          nrst,
	bmc_mode_if.path           mode,
	input  wire logic          mii_tx_en,
	input  wire logic [DW-1:0] mii_txd,
	input  wire logic          line_rx_dv,
	input  wire logic [DW-1:0] line_rxd,
	output logic               mii_rx_dv,
	output logic [DW-1:0]      mii_rxd,
	output logic               line_tx_en,
	output logic [DW-1:0]      line_txd
);
	import bmc_pkg::*;

	typedef struct packed {
		logic          rx_dv;
		logic [DW-1:0] rxd;
		logic          tx_en;
		logic [DW-1:0] txd;
	} bmc_path_st_t;

	bmc_path_st_t s_r;
	bmc_path_st_t s_nxt;

	// quiet both sides when isolated or powered down, else loop or pass
	always_comb begin
		s_nxt = '0;
		if (!(mode.isolate || mode.power_down)) begin
			if (mode.loopback) begin
				s_nxt.rx_dv = mii_tx_en;
				s_nxt.rxd   = mii_txd;
			end else begin
				s_nxt.rx_dv = line_rx_dv;
				s_nxt.rxd   = line_rxd;
				s_nxt.tx_en = mii_tx_en;
				s_nxt.txd   = mii_txd;
			end
		end
	end

	// state register
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign mii_rx_dv  = s_r.rx_dv;
	assign mii_rxd    = s_r.rxd;
	assign line_tx_en = s_r.tx_en;
	assign line_txd   = s_r.txd;
endmodule

// ==== tb/bmc_regs_chk.sv ====
// port assertions for the basic mode control bank
// assumes one core clock and the zero-wait apb port of the bank
`timescale 1ns/1ps
module bmc_regs_chk (
	input wire logic        core_clk,
	input wire logic        nrst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        an_speed_100,
	input wire logic        an_full_duplex,
	input wire logic        an_started,
	input wire logic        an_enable,
	input wire logic        an_restart,
	input wire logic        soft_reset,
	input wire logic        speed_100,
	input wire logic        full_duplex,
	input wire logic        power_down,
	input wire logic        mii_rx_dv,
	input wire logic        line_tx_en
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	logic wr_acc;

	// a write landing at this edge may legally change any mode
	assign wr_acc = psel && penable && pwrite;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	chk_ready_in_pd: assert property (power_down && psel && penable |-> pready)
		else $error("no answer while powered down");
	chk_pd_quiet: assert property (power_down && $past(power_down) |-> !mii_rx_dv && !line_tx_en)
		else $error("data moves while powered down");
	chk_err_access: assert property (pslverr |-> psel && penable)
		else $error("slave error outside access phase");
	chk_err_rdata: assert property (psel && penable && pslverr |-> prdata == 32'h0)
		else $error("refused access returns data");
	chk_swrst_hold: assert property ($rose(soft_reset) |-> ##78 soft_reset)
		else $error("software reset ended early");
	chk_swrst_end: assert property ($rose(soft_reset) |-> ##[79:83] !soft_reset)
		else $error("software reset never ended");
	chk_restart_hold: assert property (an_restart && an_enable && !an_started && !wr_acc
		|=> an_restart) else $error("restart dropped before start");
	chk_restart_clear: assert property (an_started && !wr_acc |=> !an_restart)
		else $error("restart kept after start");
	chk_speed_neg: assert property (an_enable && !soft_reset && !wr_acc |=>
		speed_100 == $past(an_speed_100) && full_duplex == $past(an_full_duplex))
		else $error("mode not taken from negotiation");
endmodule

bind bmc_regs bmc_regs_chk u_chk (
	.core_clk, .nrst, .psel, .penable, .pwrite, .prdata, .pready, .pslverr, .an_speed_100,
	.an_full_duplex, .an_started, .an_enable, .an_restart, .soft_reset, .speed_100,
	.full_duplex, .power_down, .mii_rx_dv, .line_tx_en
);

// ==== tb/bmc_neg_model.sv ====
// negotiation engine and line receiver facing the bank
// assumes restart requests and line data run on core_clk
`timescale 1ns/1ps
module bmc_neg_model #(
	parameter int LAT = 12
) (
	input  wire logic  core_clk,
	input  wire logic  nrst,
	input  wire logic  an_restart,
	output logic       an_started,
	output logic       line_rx_dv,
	output logic [3:0] line_rxd
);
	int cnt;

	// engine starts a while after a restart request; line data changes every cycle
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			cnt        <= 0;
			an_started <= 1'b0;
			line_rx_dv <= 1'b0;
			line_rxd   <= 4'h0;
		end else begin
			an_started <= an_restart && cnt == LAT;
			cnt        <= (an_restart && cnt < LAT) ? cnt + 1 : 0;
			line_rx_dv <= ~line_rx_dv;                           // receive valid toggles every cycle
			line_rxd   <= line_rxd + 4'h1;
		end
	end
endmodule

// ==== tb/bmc_regs_tb.sv ====
// self-checking bench for the basic mode control bank
// assumes the bank answers apb with zero wait states
`timescale 1ns/1ps
module testbench;
	import bmc_pkg::*;
	logic        core_clk = 0, nrst, psel, penable, pwrite, pready, pslverr, re;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0]  pstrb, mii_txd, mii_rxd, line_rxd, line_txd;
	logic        strap_an_en, strap_speed_100, strap_full_duplex, an_speed_100, an_full_duplex;
	logic        an_started, an_enable, an_restart, link_up, selftest_err, ed_err_met;
	logic        ed_pwr_state, soft_reset, speed_100, full_duplex, power_down, coll_test;
	logic        mii_tx_en, line_rx_dv, mii_rx_dv, line_tx_en;
	logic [5:0]  test_pattern_ctrl;
	logic [4:0]  energy_detect_ctrl;
	logic [15:0] rnd, rq, v;
	int          miscompares = 0, total_checks = 0, cyc = 0, n;

	bmc_regs dut (.core_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
		.pready, .pslverr, .strap_an_en, .strap_speed_100, .strap_full_duplex, .an_speed_100,
		.an_full_duplex, .an_started, .an_enable, .an_restart, .link_up, .selftest_err,
		.ed_err_met, .ed_pwr_state, .soft_reset, .speed_100, .full_duplex, .power_down,
		.coll_test, .test_pattern_ctrl, .energy_detect_ctrl, .mii_tx_en, .mii_txd, .line_rx_dv,
		.line_rxd, .mii_rx_dv, .mii_rxd, .line_tx_en, .line_txd);
	bmc_neg_model far (.core_clk, .nrst, .an_restart, .an_started, .line_rx_dv, .line_rxd);

	// ----------------------------------------------------------------
	// clock, timeout and helpers
	// ----------------------------------------------------------------
	always #12.5 core_clk = ~core_clk;

	// cut a hang short
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			miscompares++;
			print_verdict();
		end
	end

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	function automatic logic [15:0] strap_exp();
		logic [15:0] r;
		r = BMC_RST_VAL;
		r[BMC_AN_EN] = strap_an_en;
		r[BMC_SPEED] = strap_speed_100;
		r[BMC_DUPLEX] = strap_full_duplex;
		return r;
	endfunction

	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// one apb transfer; read data and error land in rq and re
	task automatic apb(input logic w, input logic [5:0] idx, input logic [15:0] d);
		@(posedge core_clk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= {idx, 2'b00};
		pwdata  <= {16'h0000, d};
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		while (pready !== 1'b1) begin
			@(posedge core_clk);
		end
		rq = prdata[15:0];
		re = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rc(input string nm, input logic [5:0] idx, input logic [15:0] exp);
		apb(1'b0, idx, 16'h0000);
		check(nm, rq, exp);
	endtask

	task automatic print_verdict();
		if (miscompares == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		rnd = 16'h0026;
		{nrst, psel, penable, pwrite, paddr, pwdata, mii_tx_en, mii_txd} = '0;
		{an_speed_100, an_full_duplex, selftest_err, ed_err_met, ed_pwr_state} = '0;
		{strap_an_en, strap_speed_100, strap_full_duplex} = {rnd[1], rnd[2], rnd[5]};
		pstrb = 4'hF;
		link_up = 1'b1;
		repeat (2) @(posedge core_clk);
		nrst <= 1'b1;
		repeat (2) @(posedge core_clk);
		rc("bmc_reset", IDX_BMC, strap_exp());
		for (int i = 0; i < 6; i++) begin
			rnd = lfsr(rnd);
			v = rnd & 16'h6DFF;
			apb(1'b1, IDX_BMC, v);
			rc("bmc_rw", IDX_BMC, v & BMC_RW_MASK);
			@(negedge core_clk);
			check("speed", 16'(speed_100), 16'(v[BMC_SPEED]));
			check("duplex", 16'(full_duplex), 16'(v[BMC_DUPLEX]));
			check("pd_coll", 16'({power_down, coll_test}), 16'({v[BMC_PDOWN], v[BMC_COLTEST]}));
		end
		// transmit active so a leak onto the line would show
		mii_tx_en <= 1'b1;
		for (int i = 0; i < 2; i++) begin
			apb(1'b1, IDX_BMC, i ? 16'h0400 : 16'h0800);
			repeat (2) @(negedge core_clk);
			check("quiet", 16'({mii_rx_dv, line_tx_en}), 16'h0000);
			rc("quiet_read", IDX_BMC, i ? 16'h0400 : 16'h0800);
		end
		// loopback first, then normal transmit to the line
		for (int m = 0; m < 2; m++) begin
			apb(1'b1, IDX_BMC, m ? 16'h0000 : 16'h4000);
			repeat (4) begin
				@(posedge core_clk);
				rnd = lfsr(rnd);
				mii_tx_en <= 1'b1;
				mii_txd   <= rnd[3:0];
				@(posedge core_clk);
				@(negedge core_clk);
				v = m ? 16'({line_tx_en, line_txd}) : 16'({mii_rx_dv, mii_rxd});
				check("tx_route", v, 16'({1'b1, rnd[3:0]}));
			end
		end
		@(posedge core_clk);
		an_speed_100   <= rnd[4];
		an_full_duplex <= rnd[5];
		apb(1'b1, IDX_BMC, 16'h3300);
		rc("restart_set", IDX_BMC, 16'h3300);
		n = 0;
		while (an_restart === 1'b1 && n < 100) begin
			@(posedge core_clk);
			n++;
		end
		rc("restart_done", IDX_BMC, 16'h3100);
		@(negedge core_clk);
		check("neg_mode", 16'({an_enable, speed_100, full_duplex}), 16'({1'b1, rnd[4], rnd[5]}));
		apb(1'b1, IDX_BMC, 16'h0200);
		rc("restart_off", IDX_BMC, 16'h0000);
		// error counter with clear on read
		apb(1'b1, IDX_TPC, 16'hFFFF);
		n = int'(rnd[3:0]) + 1;
		repeat (n) begin
			@(posedge core_clk);
			selftest_err <= 1'b1;
		end
		@(posedge core_clk);
		selftest_err <= 1'b0;
		rc("err_count", IDX_TPC, {8'(n), 8'h37});
		rc("err_clear", IDX_TPC, 16'h0037);
		check("tp_ctrl", 16'(test_pattern_ctrl), 16'h0037);
		// energy detect: latched high and mirrored state
		apb(1'b1, IDX_EDC, 16'hFFFF);
		ed_pwr_state <= 1'b1;
		ed_err_met   <= 1'b1;
		@(posedge core_clk);
		ed_err_met   <= 1'b0;
		rc("ed_latched", IDX_EDC, 16'hFEFF);
		rc("ed_released", IDX_EDC, 16'hFCFF);
		ed_pwr_state <= 1'b0;
		rc("ed_follow", IDX_EDC, 16'hF8FF);
		check("ed_ctrl", 16'(energy_detect_ctrl), 16'h001F);
		// link flag latched low beside a permanent field
		apb(1'b1, IDX_EVS, 16'h0000);
		apb(1'b0, IDX_EVS, 16'h0000);
		rc("evs_up", IDX_EVS, EVS_PERM_VAL | 16'h0001);
		link_up <= 1'b0;
		@(posedge core_clk);
		link_up <= 1'b1;
		rc("evs_drop", IDX_EVS, EVS_PERM_VAL);
		rc("evs_back", IDX_EVS, EVS_PERM_VAL | 16'h0001);
		apb(1'b1, IDX_RSV_1C, 16'hFFFF);
		rc("rsv_1c", IDX_RSV_1C, 16'h0000);
		apb(1'b0, 6'h21, 16'h0000);
		check("unmapped_err", 16'(re), 16'h0001);
		check("unmapped_data", rq, 16'h0000);
		// software reset with new straps
		rnd = lfsr(rnd);
		{strap_an_en, strap_speed_100, strap_full_duplex} <= rnd[2:0];
		apb(1'b1, IDX_BMC, 16'hC000);
		apb(1'b0, IDX_BMC, 16'h0000);
		check("swrst_busy", 16'({rq[BMC_SWRST], soft_reset}), 16'h0003);
		n = 0;
		while (rq[BMC_SWRST] === 1'b1 && n < 60) begin
			apb(1'b0, IDX_BMC, 16'h0000);
			n++;
		end
		rc("swrst_done", IDX_BMC, strap_exp());
		check("swrst_line", 16'(soft_reset), 16'h0000);
		print_verdict();
	end
endmodule
